// ### rtl/mrs_delay_timer.sv
// Purpose: start-up delay counter on watchdog oscillator ticks
// Assumes: i_tick is a one-cycle strobe per watchdog oscillator cycle
// Notes: i_clear restarts the count from zero
`timescale 1ns/100ps
module mrs_delay_timer
  import mrs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic i_short,
  output logic o_done
);
  logic [DLY_W:0] cnt;
  wire [DLY_W:0] limit = i_short ? {1'b0, DLY_SHORT} : DLY_LONG_FULL;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      cnt <= '0;
    end else if (i_tick && cnt < limit) begin
      cnt <= cnt + 15'h0001;
    end
  end
  assign o_done = (cnt >= limit);
endmodule : mrs_delay_timer

// ### rtl/mrs_ext_filter.sv
// Purpose: qualifies the external reset pin
// Assumes: pin synchronous to i_clk
// Notes: a low held EXT_MIN_CYC+1 cycles counts as a reset request
`timescale 1ns/100ps
module mrs_ext_filter
  import mrs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin_n,
  output logic o_ext_active
);
  logic [3:0] low_cnt;
  wire qualified = (low_cnt >= 4'(EXT_MIN_CYC));
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      low_cnt <= 4'h0;
    end else if (i_pin_n) begin
      low_cnt <= 4'h0;
    end else if (!qualified) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end
  // level: stays active while the pin is held low
  assign o_ext_active = qualified & ~i_pin_n;
endmodule : mrs_ext_filter

// ### rtl/mrs_pkg.sv
// Purpose: shared constants for the reset sequencer
// Assumes: 20 MHz system clock, watchdog oscillator ticks arrive as a strobe
// Notes: delay counts are in watchdog oscillator cycles
package mrs_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int EXT_MIN_NS = 50;
  // least pulse rounds up, never below one cycle
  localparam int EXT_MIN_CYC_RAW = (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_MIN_CYC = (EXT_MIN_CYC_RAW < 1) ? 1 : EXT_MIN_CYC_RAW;
  localparam int DLY_W = 14;
  localparam logic [DLY_W-1:0] DLY_SHORT = 14'h0400;
  localparam logic [DLY_W-1:0] DLY_LONG = 14'h3FFF;
  localparam logic [DLY_W:0] DLY_LONG_FULL = 15'h4000;
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [7:0] IO_INIT = 8'h00;
  localparam int IO_REGS = 4;
  typedef enum logic [1:0] {
    MRS_HOLD = 2'b00,
    MRS_COUNT = 2'b01,
    MRS_RUN = 2'b10
  } mrs_state_e;
endpackage : mrs_pkg

// ### rtl/mrs_reset_seq.sv
// Purpose: combines reset sources and sequences processor start-up
// Assumes: power-on detect, watchdog expiry and enable, and fuse are synchronous levels; the watchdog tick is a strobe
// Notes: i_reset_n models the power domain reset of this logic itself
`timescale 1ns/100ps
module mrs_reset_seq
  import mrs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_power_below_n,
  input wire logic i_ext_reset_n,
  input wire logic i_wdt_expired,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_tick,
  input wire logic i_short_startup_fuse,
  input wire logic i_irq_request,
  input wire logic i_irq_enabled,
  input wire logic [11:0] i_irq_vector,
  output logic o_core_reset,
  output logic o_wdt_pulse,
  output logic o_pc_load,
  output logic [11:0] o_pc_value,
  output logic o_irq_fetch,
  output logic [7:0] o_io_init [IO_REGS]
);
  mrs_state_e state;
  mrs_state_e next_state;
  logic ext_active;
  logic dly_done;
  logic wdt_pulse;
  logic core_reset;

  mrs_ext_filter u_ext (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin_n(i_ext_reset_n),
    .o_ext_active(ext_active)
  );

  // watchdog reset fires only when enabled, and lasts one clock
  wire wdt_fire = i_wdt_expired & i_wdt_enable;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wdt_pulse <= 1'b0;
    end else begin
      wdt_pulse <= wdt_fire & ~wdt_pulse;
    end
  end

  // power is low when the active-low detector input reads low
  wire por_active = ~i_power_below_n;
  wire any_source = por_active | ext_active | wdt_pulse;

  mrs_delay_timer u_dly (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(any_source),
    .i_tick(i_wdt_tick),
    .i_short(i_short_startup_fuse),
    .o_done(dly_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      MRS_HOLD: begin
        if (!any_source) begin
          next_state = MRS_COUNT;
        end
      end
      MRS_COUNT: begin
        if (any_source) begin
          next_state = MRS_HOLD;
        end else if (dly_done) begin
          next_state = MRS_RUN;
        end
      end
      MRS_RUN: begin
        if (any_source) begin
          next_state = MRS_HOLD;
        end
      end
      default: next_state = MRS_HOLD;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= MRS_HOLD;
    end else begin
      state <= next_state;
    end
  end

  assign core_reset = (state != MRS_RUN);
  wire release_now = (state == MRS_COUNT) && (next_state == MRS_RUN);
  wire irq_take = i_irq_request & i_irq_enabled;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_core_reset <= 1'b1;
      o_pc_load <= 1'b0;
      o_pc_value <= RESET_VECTOR;
      o_irq_fetch <= 1'b0;
    end else begin
      o_core_reset <= (next_state != MRS_RUN);
      o_pc_load <= release_now;
      // vector fetch only for an enabled source while running
      o_irq_fetch <= (next_state == MRS_RUN) && irq_take;
      if (release_now || core_reset) begin
        o_pc_value <= RESET_VECTOR;
      end else if (irq_take) begin
        o_pc_value <= i_irq_vector;
      end
    end
  end

  // i/o registers held at initial values throughout reset
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < IO_REGS; i++) begin
      if (!i_reset_n || core_reset) begin
        o_io_init[i] <= IO_INIT;
      end
    end
  end

  assign o_wdt_pulse = wdt_pulse;

  property p_wdt_one_cycle;
    @(posedge i_clk) disable iff (!i_reset_n)
      wdt_pulse |=> !wdt_pulse;
  endproperty
  a_wdt_one_cycle: assert property (p_wdt_one_cycle)
    else $error("watchdog pulse longer than one cycle");

  property p_wdt_disabled;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_wdt_enable |=> !wdt_pulse;
  endproperty
  a_wdt_disabled: assert property (p_wdt_disabled)
    else $error("watchdog reset while disabled");

  property p_por_holds;
    @(posedge i_clk) disable iff (!i_reset_n)
      por_active |=> o_core_reset;
  endproperty
  a_por_holds: assert property (p_por_holds)
    else $error("core left reset while power low");

  property p_ext_holds;
    @(posedge i_clk) disable iff (!i_reset_n)
      ext_active |=> o_core_reset;
  endproperty
  a_ext_holds: assert property (p_ext_holds)
    else $error("core left reset while pin low");

  sequence s_pin_low;
    !i_ext_reset_n [*2];
  endsequence
  property p_pin_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      s_pin_low |=> o_core_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("qualified pin low did not reset");

  property p_release_needs_done;
    @(posedge i_clk) disable iff (!i_reset_n)
      $fell(o_core_reset) |-> $past(dly_done) && !$past(any_source);
  endproperty
  a_release_needs_done: assert property (p_release_needs_done)
    else $error("release before delay complete");

  property p_pc_vector;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_pc_load |-> o_pc_value == RESET_VECTOR && !o_core_reset;
  endproperty
  a_pc_vector: assert property (p_pc_vector)
    else $error("start address not reset vector");

  property p_irq_enabled;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_irq_fetch |-> $past(i_irq_enabled) && !o_core_reset;
  endproperty
  a_irq_enabled: assert property (p_irq_enabled)
    else $error("vector fetched without enable");

  property p_restart;
    @(posedge i_clk) disable iff (!i_reset_n)
      any_source |=> o_core_reset ##1 o_core_reset;
  endproperty
  a_restart: assert property (p_restart)
    else $error("source did not restart delay");

  property p_io_init;
    @(posedge i_clk) disable iff (!i_reset_n)
      core_reset |=> o_io_init[0] == IO_INIT;
  endproperty
  a_io_init: assert property (p_io_init)
    else $error("i/o register not initialised");

  property p_wdt_fire;
    @(posedge i_clk) disable iff (!i_reset_n)
      wdt_fire && !wdt_pulse |=> wdt_pulse;
  endproperty
  a_wdt_fire: assert property (p_wdt_fire)
    else $error("enabled watchdog expiry gave no pulse");

  property p_wdt_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      wdt_pulse |=> o_core_reset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("watchdog pulse did not reset core");

  property p_wdt_restart;
    @(posedge i_clk) disable iff (!i_reset_n)
      wdt_pulse |=> !dly_done;
  endproperty
  a_wdt_restart: assert property (p_wdt_restart)
    else $error("delay not restarted by watchdog pulse");

  sequence s_pin_fall;
    i_ext_reset_n ##1 !i_ext_reset_n;
  endsequence
  property p_pin_glitch;
    @(posedge i_clk) disable iff (!i_reset_n)
      s_pin_fall |-> !ext_active;
  endproperty
  a_pin_glitch: assert property (p_pin_glitch)
    else $error("single low sample taken as reset");

  property p_source_restart;
    @(posedge i_clk) disable iff (!i_reset_n)
      any_source |=> !dly_done;
  endproperty
  a_source_restart: assert property (p_source_restart)
    else $error("delay kept counting under a source");

  sequence s_count_done;
    (state == MRS_COUNT) && dly_done && !any_source;
  endsequence
  property p_release;
    @(posedge i_clk) disable iff (!i_reset_n)
      s_count_done |=> !o_core_reset && o_pc_load;
  endproperty
  a_release: assert property (p_release)
    else $error("core not released after full delay");

  property p_no_early;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == MRS_COUNT) && !dly_done |=> o_core_reset;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("core released while delay counting");

  property p_hold_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == MRS_HOLD) |=> o_core_reset;
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("core released from hold state");

  property p_run_stays;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == MRS_RUN) && !any_source |=> !o_core_reset;
  endproperty
  a_run_stays: assert property (p_run_stays)
    else $error("core reset with no source active");

  property p_pc_load_one;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_pc_load |=> !o_pc_load;
  endproperty
  a_pc_load_one: assert property (p_pc_load_one)
    else $error("start address load longer than one cycle");

  property p_pc_in_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      core_reset |=> o_pc_value == RESET_VECTOR;
  endproperty
  a_pc_in_reset: assert property (p_pc_in_reset)
    else $error("program counter not at reset vector in reset");

  property p_irq_vector;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == MRS_RUN) && irq_take |=> o_pc_value == $past(i_irq_vector);
  endproperty
  a_irq_vector: assert property (p_irq_vector)
    else $error("enabled vector not loaded");

  property p_irq_masked;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_irq_enabled |=> !o_irq_fetch;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("vector fetched while source disabled");
endmodule : mrs_reset_seq

// ### verification/mrs_reset_seq_tb.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: watchdog tick every cycle, every other cycle in the power test
// Notes: release windows allow a few cycles of pipeline
`timescale 1ns/100ps
module mrs_reset_seq_tb;
  import mrs_pkg::*;
  logic i_clk = 0, i_reset_n = 0, up = 0, hold = 0, pwr_n, pin_n, cr, wp, pl, irf;
  logic wx = 0, we = 0, fuse = 0, ireq = 0, ien = 0, tk = 1, slow = 0;
  logic [11:0] iv = 12'h000, pcv;
  logic [7:0] io [IO_REGS];
  int err_count = 0, checked = 0, p = 0;
  integer seed = 32'hBEF74B8F;
  initial forever #25 i_clk = ~i_clk;
  // watchdog oscillator strobe, halved in rate while slow is set
  always @(posedge i_clk) tk <= slow ? ~tk : 1'b1;
  mrs_supply_model pm (.i_clk(i_clk), .i_supply_up(up), .i_hold_pin(hold),
    .o_power_below_n(pwr_n), .o_ext_reset_n(pin_n));
  mrs_reset_seq dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_power_below_n(pwr_n),
    .i_ext_reset_n(pin_n), .i_wdt_expired(wx), .i_wdt_enable(we), .i_wdt_tick(tk),
    .i_short_startup_fuse(fuse), .i_irq_request(ireq), .i_irq_enabled(ien),
    .i_irq_vector(iv), .o_core_reset(cr), .o_wdt_pulse(wp), .o_pc_load(pl),
    .o_pc_value(pcv), .o_irq_fetch(irf), .o_io_init(io));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // steps n edges, counting watchdog pulses when asked
  task automatic cyc(input int n, input logic cnt);
    repeat (n) begin
      @(posedge i_clk);
      #1;
      if (cnt && wp === 1'b1) p++;
    end
  endtask : cyc
  task automatic pin(input int n);
    @(posedge i_clk);
    hold <= 1'b1;
    repeat (n) @(posedge i_clk);
    hold <= 1'b0;
  endtask : pin
  task automatic wait_release(input int lim);
    int n;
    n = 0;
    while (cr !== 1'b0 && n < 20000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("release_cycles", 16'(n >= lim - 4 && n <= lim + 8), 16'h0001);
    check("pc_load", 16'(pl), 16'h0001);
    check("pc_value", 16'(pcv), 16'(RESET_VECTOR));
    for (int k = 0; k < IO_REGS; k++) check("io_init", 16'(io[k]), 16'(IO_INIT));
    $display("test done: release after %0d cycles", n);
  endtask : wait_release
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    hold <= 1'b1;
    up <= 1'b1;
    cyc(100, 0);
    check("held_by_pin", 16'(cr), 16'h0001);
    @(posedge i_clk);
    hold <= 1'b0;
    wait_release(16384);
    fuse <= 1'b1;
    pin(1);
    cyc(6, 0);
    check("glitch_ignored", 16'(cr), 16'h0000);
    pin(2 + ($random(seed) & 7));
    cyc(3, 0);
    check("pin_reset", 16'(cr), 16'h0001);
    cyc(500, 0);
    pin(3);
    cyc(3, 0);
    wait_release(1024);
    @(posedge i_clk);
    up <= 1'b0;
    cyc(4, 0);
    check("power_low", 16'(cr), 16'h0001);
    @(posedge i_clk);
    up <= 1'b1;
    slow <= 1'b1;
    wait_release(2048);
    @(posedge i_clk);
    slow <= 1'b0;
    wx <= 1'b1;
    cyc(10, 1);
    check("wdt_disabled", 16'(p + cr), 16'h0000);
    @(posedge i_clk);
    we <= 1'b1;
    @(posedge i_clk);
    wx <= 1'b0;
    #1;
    if (wp === 1'b1) p++;
    cyc(4, 1);
    check("wdt_pulse", 16'(p), 16'h0001);
    check("wdt_reset", 16'(cr), 16'h0001);
    wait_release(1024);
    @(posedge i_clk);
    ireq <= 1'b1;
    iv <= 12'($random(seed));
    cyc(3, 0);
    check("irq_masked", 16'(irf), 16'h0000);
    @(posedge i_clk);
    ien <= 1'b1;
    cyc(3, 0);
    check("irq_fetch", 16'(irf), 16'h0001);
    check("irq_vector", 16'(pcv), 16'(iv));
    test_done();
  end
  // whole run is about 21k cycles; cut off well beyond that
  initial begin
    #3000000;
    err_count++;
    test_done();
  end
endmodule : mrs_reset_seq_tb

// ### verification/mrs_supply_model.sv
// Purpose: supply supervisor and external reset driver model
// Assumes: commands sampled on the i_clk rising edge
// Notes: pin idles high as if pulled up
`timescale 1ns/100ps
module mrs_supply_model (
  input wire logic i_clk,
  input wire logic i_supply_up,
  input wire logic i_hold_pin,
  output logic o_power_below_n,
  output logic o_ext_reset_n
);
  initial begin
    o_power_below_n = 1'b0;
    o_ext_reset_n = 1'b1;
  end
  always @(posedge i_clk) begin
    o_power_below_n <= i_supply_up;
    o_ext_reset_n <= ~i_hold_pin;
  end
endmodule : mrs_supply_model
